// File: src/sec_defs.vh
`ifndef SEC_DEFS_VH
`define SEC_DEFS_VH

// address decode
`define SEC_SYS_BASE      32'h2000_0000
`define SEC_CODE_BASE     32'h0A00_0000
`define SEC_MAIN_BYTES    32'h0000_C000
`define SEC_SHARED_OFS    32'h0000_C000
`define SEC_SHARED_BYTES  32'h0000_1000
`define SEC_WIN_MASK      32'hFFFF_0000
`define SEC_MEM_WORDS     13312
`define SEC_MEM_AW        14

// apb register offsets
`define SEC_REG_STAT      12'h000
`define SEC_REG_CTRL      12'h004
`define SEC_REG_ERRADDR   12'h008

// status fields
`define SEC_STAT_SE_BIT   0
`define SEC_STAT_ME_BIT   1
// control fields
`define SEC_CTRL_SEIE_BIT 0
`define SEC_CTRL_MEIE_BIT 1
`define SEC_RESET_VAL     32'h0000_0000

// transfer sizes
`define SEC_SIZE_BYTE     2'h0
`define SEC_SIZE_HALF     2'h1
`define SEC_SIZE_WORD     2'h2

`endif

// File: src/sec_mem.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// word store with check bits
// ****************************************
module sec_mem #(
    parameter WORDS = 13312,
    parameter AW    = 14,
    parameter DW    = 39
) (
    // clock
    input  wire          core_clk,
    // access
    input  wire          en,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:WORDS-1];

    always @(posedge core_clk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule

`default_nettype wire

// File: src/sec_ecc.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// secded encoder and decoder
// ****************************************
module sec_ecc (
    // encoder
    input  wire [31:0] enc_data,
    output wire [6:0]  enc_code,
    // decoder
    input  wire [31:0] dec_data,
    input  wire [6:0]  dec_code,
    output reg  [31:0] dec_fixed,
    output reg         dec_single,
    output reg         dec_multi,
    output reg  [5:0]  dec_bitpos
);
    // hamming position of data bit i (skips powers of two)
    function [5:0] hpos;
        input [5:0] i;
        integer k;
        reg [5:0] p;
        begin
            p = 6'h3;
            for (k = 0; k < 32; k = k + 1) begin
                if (k < i) begin
                    p = p + 6'h1;
                    if (p == 6'h4 || p == 6'h8 || p == 6'h10 || p == 6'h20) begin
                        p = p + 6'h1;
                    end
                end
            end
            hpos = p;
        end
    endfunction

    // six hamming bits plus overall parity
    function [6:0] gen;
        input [31:0] d;
        integer i;
        reg [5:0] s;
        begin
            s = 6'h0;
            for (i = 0; i < 32; i = i + 1) begin
                if (d[i]) begin
                    s = s ^ hpos(i[5:0]);
                end
            end
            gen = {^d ^ ^s, s};
        end
    endfunction

    assign enc_code = gen(enc_data);

    reg [6:0] chk;
    reg [5:0] syn;
    reg       par;
    integer   j;

    always @* begin
        chk        = gen(dec_data);
        syn        = chk[5:0] ^ dec_code[5:0];
        par        = ^dec_data ^ ^dec_code;
        dec_fixed  = dec_data;
        dec_single = 1'b0;
        dec_multi  = 1'b0;
        dec_bitpos = 6'h3F;
        if (syn != 6'h0 && !par) begin
            dec_multi = 1'b1;
        end else if (par) begin
            dec_single = 1'b1;
            for (j = 0; j < 32; j = j + 1) begin
                if (hpos(j[5:0]) == syn) begin
                    dec_fixed[j] = ~dec_data[j];
                    dec_bitpos   = j[5:0];
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: src/sec_ctrl.v
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sec_defs.vh"

module sec_ctrl #(
    parameter WORDS = `SEC_MEM_WORDS,
    parameter AW    = `SEC_MEM_AW
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // memory request
    input  wire        mem_req,
    input  wire        mem_write,
    input  wire [1:0]  mem_size,
    input  wire [31:0] mem_addr,
    input  wire [31:0] mem_wdata,
    output reg         mem_ready,
    output reg         mem_err,
    output reg  [31:0] mem_rdata,
    // apb
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // interrupts
    output reg         ecc_irq,
    output reg         ecc_nmi
);
    // ****************************************
    // states
    // ****************************************
    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_CHECK = 2'h2;
    localparam ST_DONE  = 2'h3;

    reg [1:0]  state_q;
    reg [AW-1:0] waddr_q;
    reg [31:0] baddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  be_q;
    reg        write_q;
    reg        se_flag_q;
    reg        me_flag_q;
    reg        seie_q;
    reg        meie_q;
    reg [31:0] err_addr_q;

    // ****************************************
    // decode
    // ****************************************
    // byte offset in sram or all ones when unmapped
    function [31:0] sram_ofs;
        input [31:0] a;
        reg [31:0] o;
        begin
            o = a & ~`SEC_WIN_MASK;
            if ((a & `SEC_WIN_MASK) == `SEC_SYS_BASE
                    || (a & `SEC_WIN_MASK) == `SEC_CODE_BASE) begin
                if (o < `SEC_MAIN_BYTES) begin
                    sram_ofs = o;
                end else if (o < `SEC_SHARED_OFS + `SEC_SHARED_BYTES) begin
                    sram_ofs = o;
                end else begin
                    sram_ofs = 32'hFFFF_FFFF;
                end
            end else begin
                sram_ofs = 32'hFFFF_FFFF;
            end
        end
    endfunction

    // lane enables from size and low address
    function [3:0] lanes;
        input [1:0] sz;
        input [1:0] lo;
        begin
            if (sz == `SEC_SIZE_BYTE) begin
                lanes = 4'h1 << lo;
            end else if (sz == `SEC_SIZE_HALF) begin
                lanes = lo[1] ? 4'hC : 4'h3;
            end else begin
                lanes = 4'hF;
            end
        end
    endfunction

    wire [31:0] req_ofs = sram_ofs(mem_addr);
    wire        req_hit = (req_ofs != 32'hFFFF_FFFF);
    wire [3:0]  req_be  = lanes(mem_size, mem_addr[1:0]);

    // ****************************************
    // ecc and storage
    // ****************************************
    reg         ram_en;
    reg         ram_we;
    reg [AW-1:0] ram_addr;
    reg [31:0]  ram_wdata;
    wire [38:0] ram_rdata;
    wire [6:0]  enc_code;
    wire [31:0] fixed;
    wire        dec_single;
    wire        dec_multi;
    reg  [31:0] merged;
    integer     b;

    sec_ecc u_ecc (
        .enc_data   (ram_wdata),
        .enc_code   (enc_code),
        .dec_data   (ram_rdata[31:0]),
        .dec_code   (ram_rdata[38:32]),
        .dec_fixed  (fixed),
        .dec_single (dec_single),
        .dec_multi  (dec_multi),
        .dec_bitpos ()
    );

    sec_mem #(
        .WORDS (WORDS),
        .AW    (AW),
        .DW    (39)
    ) u_mem (
        .core_clk (core_clk),
        .en       (ram_en),
        .we       (ram_we),
        .addr     (ram_addr),
        .wdata    ({enc_code, ram_wdata}),
        .rdata    (ram_rdata)
    );

    // merge new bytes into corrected word
    always @* begin
        merged = fixed;
        for (b = 0; b < 4; b = b + 1) begin
            if (be_q[b]) begin
                merged[b*8 +: 8] = wdata_q[b*8 +: 8];
            end
        end
    end

    wire accept = (state_q == ST_IDLE) && mem_req && req_hit;
    wire full_w = mem_write && (req_be == 4'hF);
    wire ecc_chk = (state_q == ST_CHECK);
    wire ev_se  = ecc_chk && dec_single;
    wire ev_me  = ecc_chk && dec_multi;

    always @* begin
        ram_en    = 1'b0;
        ram_we    = 1'b0;
        ram_addr  = waddr_q;
        ram_wdata = merged;
        if (accept) begin
            ram_en    = 1'b1;
            ram_we    = full_w;
            ram_addr  = req_ofs[AW+1:2];
            ram_wdata = mem_wdata;
        end else if (ecc_chk && write_q && !dec_multi) begin
            ram_en = 1'b1; // write back merged word with fresh code
            ram_we = 1'b1;
        end
    end

    // ****************************************
    // access sequencer
    // ****************************************
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            waddr_q   <= {AW{1'b0}};
            baddr_q   <= 32'h0000_0000;
            wdata_q   <= 32'h0000_0000;
            be_q      <= 4'h0;
            write_q   <= 1'b0;
            mem_ready <= 1'b0;
            mem_err   <= 1'b0;
            mem_rdata <= 32'h0000_0000;
        end else begin
            mem_ready <= 1'b0;
            mem_err   <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (mem_req && !req_hit) begin
                        mem_ready <= 1'b1;
                        mem_err   <= 1'b1;
                        state_q   <= ST_DONE;
                    end else if (accept) begin
                        waddr_q <= req_ofs[AW+1:2];
                        baddr_q <= mem_addr;
                        wdata_q <= mem_wdata;
                        be_q    <= req_be;
                        write_q <= mem_write;
                        if (full_w) begin
                            mem_ready <= 1'b1;
                            state_q   <= ST_DONE;
                        end else begin
                            state_q <= ST_READ;
                        end
                    end
                end
                ST_READ: begin
                    state_q <= ST_CHECK;
                end
                ST_CHECK: begin
                    mem_ready <= 1'b1;
                    mem_err   <= dec_multi;
                    mem_rdata <= fixed;
                    state_q   <= ST_DONE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // error flags and registers
    // ****************************************
    // writes land only at the access edge that samples pready high
    wire apb_wr = psel && penable && pwrite && pready;
    wire clr_se = apb_wr && paddr == `SEC_REG_STAT && pwdata[`SEC_STAT_SE_BIT];
    wire clr_me = apb_wr && paddr == `SEC_REG_STAT && pwdata[`SEC_STAT_ME_BIT];

    always @(posedge core_clk) begin
        if (!rst_n) begin
            se_flag_q  <= 1'b0;
            me_flag_q  <= 1'b0;
            seie_q     <= 1'b0;
            meie_q     <= 1'b0;
            err_addr_q <= `SEC_RESET_VAL;
            ecc_irq    <= 1'b0;
            ecc_nmi    <= 1'b0;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            // set wins over clear
            if (ev_se) begin
                se_flag_q <= 1'b1;
            end else if (clr_se) begin
                se_flag_q <= 1'b0;
            end
            if (ev_me) begin
                me_flag_q <= 1'b1;
            end else if (clr_me) begin
                me_flag_q <= 1'b0;
            end
            if (ev_se || ev_me) begin
                err_addr_q <= baddr_q;
            end
            ecc_irq <= (se_flag_q || ev_se) && seie_q && !(clr_se && !ev_se);
            ecc_nmi <= (me_flag_q || ev_me) && meie_q && !(clr_me && !ev_me);
            pready  <= psel && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !pready) begin
                if (paddr == `SEC_REG_STAT) begin
                    prdata <= {30'h0, me_flag_q, se_flag_q};
                end else if (paddr == `SEC_REG_CTRL) begin
                    prdata <= {30'h0, meie_q, seie_q};
                end else if (paddr == `SEC_REG_ERRADDR) begin
                    prdata <= err_addr_q;
                end else begin
                    pslverr <= 1'b1;
                end
            end
            if (apb_wr && paddr == `SEC_REG_CTRL) begin
                seie_q <= pwdata[`SEC_CTRL_SEIE_BIT];
                meie_q <= pwdata[`SEC_CTRL_MEIE_BIT];
            end
        end
    end
endmodule

`default_nettype wire

// File: dv/sec_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// port checker for the sram controller
// ****************************************
module sec_ctrl_monitor (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // memory bus
    input wire logic        mem_req,
    input wire logic        mem_write,
    input wire logic [1:0]  mem_size,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ready,
    input wire logic        mem_err,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // interrupts
    input wire logic        ecc_irq,
    input wire logic        ecc_nmi
);
    logic mapped;
    logic full_wr;

    assign mapped = (mem_addr[31:16] == 16'h2000 || mem_addr[31:16] == 16'h0A00)
                    && mem_addr[15:0] < 16'hD000;
    assign full_wr = mem_write && mem_size == 2'h2;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        $rose(mem_req);
    endsequence
    sequence s_wait_long;
        !mem_ready [*2] ##[1:2] mem_ready;
    endsequence

    AST_LONG_LAT: assert property (s_start ##0 (mapped && !full_wr) |-> s_wait_long)
        else $error("long access answered at wrong time");
    AST_WORD_WR: assert property (s_start ##0 (mapped && full_wr) |-> ##[1:2] (mem_ready && !mem_err))
        else $error("word write not answered cleanly");
    AST_UNMAP: assert property (s_start ##0 !mapped |-> ##[1:2] (mem_ready && mem_err))
        else $error("unmapped access not refused");
    AST_RDY_PULSE: assert property (mem_ready |=> !mem_ready)
        else $error("ready longer than one cycle");
    AST_ERR_QUAL: assert property (mem_err |-> mem_ready)
        else $error("error without ready");
    AST_APB_RDY: assert property (psel && !penable |=> pready)
        else $error("apb ready late");
    AST_APB_ERR: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h008))
        else $error("apb slave error wrong");
    AST_IRQ_CLR: assert property (pready && pwrite && paddr == 12'h000 && pwdata[0] && !mem_req
        |-> ##2 !ecc_irq)
        else $error("irq stays after flag clear");
    AST_IRQ_OFF: assert property (pready && pwrite && paddr == 12'h004 && !pwdata[0] && !mem_req
        |-> ##2 !ecc_irq)
        else $error("irq without enable");
    AST_NMI_OFF: assert property (pready && pwrite && paddr == 12'h004 && !pwdata[1] && !mem_req
        |-> ##2 !ecc_nmi)
        else $error("nmi without enable");
    AST_RST: assert property ($rose(rst_n) |-> !ecc_irq && !ecc_nmi && !mem_ready && !pready)
        else $error("outputs not clear after reset");
endmodule

bind sec_ctrl sec_ctrl_monitor i_mon (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .mem_req   (mem_req),
    .mem_write (mem_write),
    .mem_size  (mem_size),
    .mem_addr  (mem_addr),
    .mem_ready (mem_ready),
    .mem_err   (mem_err),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .ecc_irq   (ecc_irq),
    .ecc_nmi   (ecc_nmi)
);

`default_nettype wire

// File: dv/sec_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bus master on the memory side
// ****************************************
module sec_master_model (
    // clock
    input  wire logic        core_clk,
    // answer
    input  wire logic        mem_ready,
    input  wire logic        mem_err,
    input  wire logic [31:0] mem_rdata,
    // request
    output logic             mem_req,
    output logic             mem_write,
    output logic [1:0]       mem_size,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata
);
    initial begin
        mem_req = 1'b0;
        mem_write = 1'b0;
        mem_size = 2'h0;
        mem_addr = 32'h0000_0000;
        mem_wdata = 32'h0000_0000;
    end

    // one transfer, idle gap first, held until ready
    task automatic xfer(input logic w, input logic [1:0] sz, input logic [31:0] a,
                        input logic [31:0] d, input int gap,
                        output logic [31:0] rd, output logic er);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        mem_req <= 1'b1;
        mem_write <= w;
        mem_size <= sz;
        mem_addr <= a;
        mem_wdata <= d;
        do begin
            @(posedge core_clk);
        end while (mem_ready !== 1'b1);
        rd = mem_rdata;
        er = mem_err;
        // released lines show no stale value
        mem_req <= 1'b0;
        mem_addr <= ~a;
        mem_wdata <= ~d;
    endtask
endmodule

`default_nettype wire

// File: dv/sram_ecc_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sec_defs.vh"

module sram_ecc_controller_tb;
    logic        core_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mem_req;
    logic        mem_write;
    logic [1:0]  mem_size;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic        mem_ready;
    logic        mem_err;
    logic        ecc_irq;
    logic        ecc_nmi;
    int          mismatches;
    int          num_checks;
    logic [31:0] rd;
    logic        er;

    sec_ctrl i_dut (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .mem_req   (mem_req),
        .mem_write (mem_write),
        .mem_size  (mem_size),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_ready (mem_ready),
        .mem_err   (mem_err),
        .mem_rdata (mem_rdata),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .ecc_irq   (ecc_irq),
        .ecc_nmi   (ecc_nmi)
    );

    sec_master_model i_mst (
        .core_clk  (core_clk),
        .mem_ready (mem_ready),
        .mem_err   (mem_err),
        .mem_rdata (mem_rdata),
        .mem_req   (mem_req),
        .mem_write (mem_write),
        .mem_size  (mem_size),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        apb(1'b0, `SEC_REG_STAT, 32'h0);
        chk(rd, `SEC_RESET_VAL);
        apb(1'b0, `SEC_REG_ERRADDR, 32'h0);
        chk(rd, `SEC_RESET_VAL);
        apb(1'b1, `SEC_REG_CTRL, 32'h0000_0003);
        apb(1'b0, `SEC_REG_CTRL, 32'h0);
        chk(rd, 32'h0000_0003);
        apb(1'b1, `SEC_REG_STAT, 32'h0000_0003);
        apb(1'b0, `SEC_REG_STAT, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({ecc_nmi, ecc_irq}, 2'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(er, 1'b1);
        $display("test regs done");
    endtask

    task automatic t_word;
        logic [31:0] a [4] = '{32'h2000_0000, 32'h2000_BFFC, 32'h2000_C000, 32'h2000_CFFC};
        for (int i = 0; i < 4; i++) begin
            i_mst.xfer(1'b1, `SEC_SIZE_WORD, a[i], a[i] ^ 32'hC35A_0F00, i, rd, er);
            chk(er, 1'b0);
            i_mst.xfer(1'b0, `SEC_SIZE_WORD, a[i] ^ 32'h2A00_0000, 32'h0, 0, rd, er);
            chk(rd, a[i] ^ 32'hC35A_0F00);
            chk(er, 1'b0);
        end
        $display("test word done");
    endtask

    task automatic t_narrow;
        i_mst.xfer(1'b1, `SEC_SIZE_WORD, 32'h2000_0100, 32'h1122_3344, 0, rd, er);
        i_mst.xfer(1'b1, `SEC_SIZE_BYTE, 32'h2000_0101, 32'h0000_AA00, 0, rd, er);
        chk(er, 1'b0);
        i_mst.xfer(1'b1, `SEC_SIZE_HALF, 32'h0A00_0102, 32'hBEEF_0000, 2, rd, er);
        chk(er, 1'b0);
        i_mst.xfer(1'b0, `SEC_SIZE_BYTE, 32'h2000_0103, 32'h0, 0, rd, er);
        chk(rd, 32'hBEEF_AA44);
        chk(er, 1'b0);
        $display("test narrow done");
    endtask

    task automatic t_err;
        i_mst.xfer(1'b1, `SEC_SIZE_WORD, 32'h2000_0200, 32'h5A5A_1234, 0, rd, er);
        i_dut.u_mem.mem[14'h080] = i_dut.u_mem.mem[14'h080] ^ 39'h00_0000_0020;
        i_mst.xfer(1'b0, `SEC_SIZE_WORD, 32'h2000_0200, 32'h0, 0, rd, er);
        chk(rd, 32'h5A5A_1234);
        chk(er, 1'b0);
        chk({ecc_nmi, ecc_irq}, 2'h1);
        apb(1'b0, `SEC_REG_STAT, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, `SEC_REG_ERRADDR, 32'h0);
        chk(rd, 32'h2000_0200);
        apb(1'b1, `SEC_REG_STAT, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        chk({ecc_nmi, ecc_irq}, 2'h0);
        i_dut.u_mem.mem[14'h080] = i_dut.u_mem.mem[14'h080] ^ 39'h00_0000_0001;
        i_mst.xfer(1'b0, `SEC_SIZE_WORD, 32'h0A00_0200, 32'h0, 0, rd, er);
        chk(er, 1'b1);
        chk({ecc_nmi, ecc_irq}, 2'h2);
        apb(1'b0, `SEC_REG_STAT, 32'h0);
        chk(rd, 32'h0000_0002);
        apb(1'b0, `SEC_REG_ERRADDR, 32'h0);
        chk(rd, 32'h0A00_0200);
        apb(1'b1, `SEC_REG_STAT, 32'h0000_0002);
        repeat (2) @(posedge core_clk);
        chk({ecc_nmi, ecc_irq}, 2'h0);
        i_mst.xfer(1'b1, `SEC_SIZE_WORD, 32'h2000_0200, 32'h0, 0, rd, er);
        $display("test ecc done");
    endtask

    task automatic t_unmap;
        logic [31:0] a [3] = '{32'h2000_D000, 32'h0A00_D000, 32'h1000_0000};
        for (int i = 0; i < 3; i++) begin
            i_mst.xfer(i[0], `SEC_SIZE_WORD, a[i], 32'h0, 0, rd, er);
            chk(er, 1'b1);
        end
        apb(1'b0, `SEC_REG_STAT, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({ecc_nmi, ecc_irq}, 2'h0);
        apb(1'b1, `SEC_REG_CTRL, 32'h0);
        $display("test unmapped done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        mismatches = 0;
        num_checks = 0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_word();
        t_narrow();
        t_err();
        t_unmap();
        results();
    end
endmodule

`default_nettype wire
